//--- src/strap_dev.sv
// Purpose: controller end: samples straps, reports progress and errors
// Assumes: chipset reset arrives as power_on pin, synchronised here
// Notes:   startup sequence is a small fsm
//          level outputs are flops, valid with init_done
//          power_on low restarts the whole sequence
// How it works
// R1 - sample all straps during startup
// R2 - hold strap selects boot or main
// R3 - host select picks spi or i2c
// R4 - other port is read-only diagnostic
// R5 - integrity strap picks crc or checksum
// R6 - diagnostic port uses same integrity choice (code: only while hold strap is low, else crc)
// R7 - mode strap selects allowed spi modes
// R8 - mode numbering is polarity and phase
// R9 - mode pin becomes progress toggle output
// R10 - toggling starts right after sampling
// R11 - toggle for every optional event
// R12 - override low keeps spread spectrum off
// R13 - override high defers to flash (code: only while hold strap is low, else off)
// R14 - interrupt when error parks mirror array
// R15 - host drives chipset power-on reset
// R16 - interrupt is driven high
// R17 - host keeps straps stable until sampled
//
// The APB slave port and the placing of the registers were left to the implementer.
module strap_dev
  import strap_pkg::*;
#(
  parameter int SETTLE = strap_pkg::SETTLE_CYC,
  parameter int STAGE  = strap_pkg::STAGE_CYC,
  parameter int STAGES = strap_pkg::NUM_STAGES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  strap_if.dev      pins,
  input  wire logic flash_ss_enable,
  input  wire logic fault,
  output logic      running_main,
  output logic      boot_wait,
  output logic      spi_is_host,
  output logic      i2c_is_host,
  output logic      spi_diag_ro,
  output logic      i2c_diag_ro,
  output logic      use_checksum,
  output logic      diag_use_checksum,
  output logic      spi_cpol_ok0,
  output logic      spi_cpol_ok1,
  output logic      spread_enable,
  output logic      init_done,
  output logic      standby
);
  import strap_pkg::*;
  typedef enum logic [1:0] {
    S_OFF    = 2'b00,
    S_SETTLE = 2'b01,
    S_INIT   = 2'b10,
    S_RUN    = 2'b11
  } dev_state_e;
  dev_state_e  state_reg;
  logic [5:0]  pin_s;
  logic [31:0] cnt_reg;
  logic [7:0]  stage_reg;
  logic [5:0]  cap_reg;
  logic        tog_reg;
  logic        park_reg;
  // stage and window decodes
  logic        settle_end;
  logic        stage_end;
  logic        last_stage;
  logic        in_run;
  // positions of the synchronised pins
  localparam int SYN_POWER = 5;
  localparam int CAP_HOLD  = 4;
  localparam int CAP_HOST  = 3;
  localparam int CAP_INTEG = 2;
  localparam int CAP_MODE  = 1;
  localparam int CAP_SSOVR = 0;
  sync2 #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({pins.power_on, pins.boot_hold_mode, pins.host_sel_strap,
               pins.integrity_select_strap, pins.spi_mode_pin,
               pins.test_point_five_pin}),
    .q       (pin_s)
  );
  // end of settle window and of each stage
  assign settle_end = state_reg == S_SETTLE && cnt_reg >= 32'(SETTLE - 1);
  assign stage_end  = state_reg == S_INIT && cnt_reg >= 32'(STAGE - 1);
  assign last_stage = stage_reg == 8'(STAGES);
  assign in_run     = state_reg == S_RUN;
  // R15 chipset reset from host pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= S_OFF;
    else if (!pin_s[SYN_POWER])
      state_reg <= S_OFF;
    else
    begin
      unique case (state_reg)
        S_OFF:    state_reg <= S_SETTLE;
        // R17 wait for straps to settle
        S_SETTLE: if (settle_end) state_reg <= S_INIT;
        S_INIT:   if (last_stage && stage_end)
                    state_reg <= S_RUN;
        S_RUN:    state_reg <= S_RUN;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= '0;
    else if (state_reg == S_OFF)
      cnt_reg <= '0;
    else if (settle_end || stage_end)
      cnt_reg <= '0;
    else if (state_reg != S_RUN)
      cnt_reg <= cnt_reg + 32'd1;
  end
  // R1 capture every strap once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_reg <= '0;
    else if (settle_end)
      cap_reg <= {1'b0, pin_s[CAP_HOLD:CAP_SSOVR]};
  end
  // R11 one toggle per stage, optional or not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_reg <= '0;
      tog_reg   <= 1'b0;
    end
    else if (state_reg == S_OFF)
    begin
      stage_reg <= '0;
      tog_reg   <= 1'b0;
    end
    // R10 first toggle right after capture
    else if (settle_end)
    begin
      stage_reg <= 8'h01;
      tog_reg   <= ~pin_s[CAP_MODE];
    end
    else if (stage_end && !last_stage)
    begin
      stage_reg <= stage_reg + 8'h01;
      tog_reg   <= ~tog_reg;
    end
  end
  // R14 error parks array, enter standby
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      park_reg <= 1'b0;
    else if (state_reg == S_OFF)
      park_reg <= 1'b0;
    else if (in_run && fault)
      park_reg <= 1'b1;
  end
  // R9 pin turns to output after capture
  assign pins.spi_mode_oe_dev = (state_reg == S_INIT) || (state_reg == S_RUN);
  assign pins.spi_mode_o_dev  = tog_reg;
  // R16 interrupt high on serious error
  assign pins.host_irq        = park_reg;
  // level outputs, one cycle after state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_wait         <= 1'b0;
      running_main      <= 1'b0;
      spi_is_host       <= 1'b0;
      i2c_is_host       <= 1'b0;
      spi_diag_ro       <= 1'b0;
      i2c_diag_ro       <= 1'b0;
      use_checksum      <= 1'b0;
      diag_use_checksum <= 1'b0;
      spi_cpol_ok0      <= 1'b0;
      spi_cpol_ok1      <= 1'b0;
      spread_enable     <= 1'b0;
      init_done         <= 1'b0;
    end
    else
    begin
      // R2 boot hold versus main
      boot_wait         <= in_run && cap_reg[CAP_HOLD];
      running_main      <= in_run && !cap_reg[CAP_HOLD];
      // R3 host port choice
      spi_is_host       <= in_run && !cap_reg[CAP_HOST];
      i2c_is_host       <= in_run && cap_reg[CAP_HOST];
      // R4 unselected port read-only diagnostic
      spi_diag_ro       <= in_run && cap_reg[CAP_HOST];
      i2c_diag_ro       <= in_run && !cap_reg[CAP_HOST];
      // R5 integrity scheme for host port
      use_checksum      <= cap_reg[CAP_INTEG] == INTEG_SUM;
      // R6 same scheme on diagnostic port, only while hold strap is low
      diag_use_checksum <= in_run && !cap_reg[CAP_HOLD] && cap_reg[CAP_INTEG] == INTEG_SUM;
      // R7 R8 allowed modes as polarity pairs
      spi_cpol_ok0      <= cap_reg[CAP_MODE] == MODES_0_3;
      spi_cpol_ok1      <= cap_reg[CAP_MODE] != MODES_0_3;
      // R12 R13 override gates flash setting
      spread_enable     <= in_run && !cap_reg[CAP_HOLD] && cap_reg[CAP_SSOVR] && flash_ss_enable;
      // run flag, qualifies the levels above except use_checksum and spi_cpol_ok0/1
      init_done         <= in_run;
    end
  end
  assign standby              = park_reg;
endmodule

//--- src/strap_pkg.sv
// Purpose: shared constants for strap sampling and its host end
// Assumes: one clock pclk at 50 MHz, presetn async active low
// Notes:   apb offsets and timing counts
package strap_pkg;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          STRAP_SETTLE_NS = 1000;
  localparam int          SETTLE_CYC     = (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          STAGE_NS       = 200;
  localparam int          STAGE_CYC      = (STAGE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          NUM_STAGES     = 8;
  localparam logic [11:0] CTRL_OFF       = 12'h000;
  localparam logic [11:0] STAT_OFF       = 12'h004;
  localparam logic [11:0] CFG_OFF        = 12'h008;
  localparam logic [11:0] IRQ_STAT_OFF   = 12'h00C;
  localparam logic [11:0] IRQ_MASK_OFF   = 12'h010;
  localparam logic [31:0] RESET_VAL      = 32'h0000_0000;
  localparam logic [31:0] STRAP_DEF      = 32'h0000_0000;
  // ctrl fields
  localparam int          C_POWER_ON     = 0;
  localparam int          C_BOOT_HOLD    = 1;
  localparam int          C_HOST_SEL     = 2;
  localparam int          C_INTEG        = 3;
  localparam int          C_SPI_MODE     = 4;
  localparam int          C_SS_OVR       = 5;
  localparam int          C_FLASH_SS     = 6;
  localparam int          C_FAULT        = 7;
  // status / irq bits
  localparam int          S_DONE         = 0;
  localparam int          S_TOGGLE       = 1;
  localparam int          S_FAULT        = 2;
  localparam int          IRQ_W          = 3;
  localparam int          TOG_W          = 8;
  // integrity scheme and spi mode pair
  localparam logic        INTEG_CRC      = 1'b0;
  localparam logic        INTEG_SUM      = 1'b1;
  localparam logic        MODES_0_3      = 1'b0;
endpackage

//--- src/strap_if.sv
// Purpose: pins between the controller and its host processor
// Assumes: single clock domain, straps are board levels
// Notes:   the spi-mode pin is two-way, resolved here
interface strap_if;
  logic power_on;
  logic boot_hold_mode;
  logic host_sel_strap;
  logic integrity_select_strap;
  logic spi_mode_o_host;
  logic spi_mode_oe_host;
  logic spi_mode_o_dev;
  logic spi_mode_oe_dev;
  logic test_point_five_pin;
  logic host_irq;
  logic spi_mode_pin;
  assign spi_mode_pin = spi_mode_oe_dev ? spi_mode_o_dev :
                        spi_mode_oe_host ? spi_mode_o_host : 1'b0;
  modport dev (
    input  power_on, boot_hold_mode, host_sel_strap, integrity_select_strap,
    input  test_point_five_pin, spi_mode_pin,
    output spi_mode_o_dev, spi_mode_oe_dev, host_irq
  );
  modport host (
    output power_on, boot_hold_mode, host_sel_strap, integrity_select_strap,
    output test_point_five_pin, spi_mode_o_host, spi_mode_oe_host,
    input  spi_mode_pin, spi_mode_oe_dev, host_irq
  );
endinterface

//--- src/sync2.sv
// Purpose: two-flop synchroniser bank
// Assumes: async inputs
// Notes:   first stage read only by the second
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

//--- src/strap_host.sv
// Purpose: host end: apb registers drive straps and reset, watch irq
// Assumes: apb slave, zero wait states
// Notes:   status bits sticky, cleared by read
module strap_host
  import strap_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  strap_if.host            pins,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  import strap_pkg::*;
  logic [7:0]       ctrl_reg;
  logic [IRQ_W-1:0] ist_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [TOG_W-1:0] tog_cnt_reg;
  logic [2:0]       in_s;
  logic             in_d_reg;
  logic             irq_d_reg;
  logic             oe_d_reg;
  logic             wr;
  logic             rd;
  logic [IRQ_W-1:0] ev;
  sync2 #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({pins.spi_mode_pin, pins.host_irq, pins.spi_mode_oe_dev}),
    .q       (in_s)
  );
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= '0;
    else if (wr && paddr == CTRL_OFF)
      ctrl_reg <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_d_reg  <= 1'b0;
      irq_d_reg <= 1'b0;
      oe_d_reg  <= 1'b0;
    end
    else
    begin
      in_d_reg  <= in_s[2];
      irq_d_reg <= in_s[1];
      oe_d_reg  <= in_s[0];
    end
  end
  // R11 count progress toggles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog_cnt_reg <= '0;
    else if (!ctrl_reg[C_POWER_ON])
      tog_cnt_reg <= '0;
    else if (in_s[0] && oe_d_reg && in_s[2] != in_d_reg)
      tog_cnt_reg <= tog_cnt_reg + 1'b1;
  end
  assign ev[S_DONE]   = in_s[0] && !oe_d_reg;
  assign ev[S_TOGGLE] = in_s[0] && oe_d_reg && in_s[2] != in_d_reg;
  assign ev[S_FAULT]  = in_s[1] && !irq_d_reg;
  // sticky status, set beats read-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ist_reg <= '0;
    else if (rd && paddr == IRQ_STAT_OFF)
      ist_reg <= ev;
    else
      ist_reg <= ist_reg | ev;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_reg <= '0;
    else if (wr && paddr == IRQ_MASK_OFF)
      imask_reg <= pwdata[IRQ_W-1:0];
  end
  always_comb
  begin
    prdata = RESET_VAL;
    unique case (paddr)
      CTRL_OFF:     prdata = {24'h000000, ctrl_reg};
      STAT_OFF:     prdata = {21'h000000, tog_cnt_reg, in_s[0], in_s[1], in_s[2]};
      CFG_OFF:      prdata = 32'(SETTLE_CYC);
      IRQ_STAT_OFF: prdata = {29'h00000000, ist_reg};
      IRQ_MASK_OFF: prdata = {29'h00000000, imask_reg};
      default:      prdata = RESET_VAL;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == CTRL_OFF || paddr == STAT_OFF ||
                   paddr == CFG_OFF || paddr == IRQ_STAT_OFF || paddr == IRQ_MASK_OFF);
  assign irq     = |(ist_reg & imask_reg);
  // R15 host drives chipset reset
  assign pins.power_on               = ctrl_reg[C_POWER_ON];
  // R17 straps held from register levels
  assign pins.boot_hold_mode         = ctrl_reg[C_BOOT_HOLD];
  assign pins.host_sel_strap         = ctrl_reg[C_HOST_SEL];
  // R5 host picks matching integrity
  assign pins.integrity_select_strap = ctrl_reg[C_INTEG];
  assign pins.test_point_five_pin    = ctrl_reg[C_SS_OVR];
  // R7 drive mode strap until device takes pin
  assign pins.spi_mode_o_host        = ctrl_reg[C_SPI_MODE];
  assign pins.spi_mode_oe_host       = !in_s[0];
endmodule

//--- verification/strap_chk_sva.sv
// Purpose: pin-level checks between controller end and host end
// Assumes: one clock pclk, presetn async active low
// Notes:   STAGE and STAGES follow the device instance
module strap_chk #(
  parameter int STAGE  = 10,
  parameter int STAGES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on,
  input wire logic spi_mode_pin,
  input wire logic spi_mode_o_dev,
  input wire logic spi_mode_oe_dev,
  input wire logic host_irq
);
  int gap;
  int tog_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since last toggle, toggles so far
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap     <= 0;
      tog_cnt <= 0;
    end
    else if (!spi_mode_oe_dev || $rose(spi_mode_oe_dev))
    begin
      gap     <= 0;
      tog_cnt <= spi_mode_oe_dev ? 1 : 0;
    end
    else if ($changed(spi_mode_o_dev))
    begin
      gap     <= 0;
      tog_cnt <= tog_cnt + 1;
    end
    else
      gap <= gap + 1;
  end
  a_first_toggle: assert property ($rose(spi_mode_oe_dev) |->
    spi_mode_o_dev == !$past(spi_mode_pin)) else $error("first toggle not inverted");
  a_oe_needs_power: assert property ($rose(spi_mode_oe_dev) |-> power_on)
    else $error("pin driven without power on");
  a_release_off: assert property ($fell(power_on) |-> ##[1:6] !spi_mode_oe_dev)
    else $error("pin not released after power off");
  a_irq_drop_off: assert property ($fell(power_on) |-> ##[1:6] !host_irq)
    else $error("host irq kept after power off");
  a_irq_in_run: assert property ($rose(host_irq) |-> spi_mode_oe_dev && tog_cnt == STAGES)
    else $error("host irq outside run");
  a_irq_held: assert property (host_irq && power_on |=> host_irq)
    else $error("host irq dropped early");
  a_stage_gap: assert property (spi_mode_oe_dev && !$rose(spi_mode_oe_dev)
    && $changed(spi_mode_o_dev) |-> gap == STAGE - 1) else $error("toggle spacing wrong");
  a_all_stages: assert property (gap == STAGE |-> tog_cnt == STAGES)
    else $error("toggling stopped early");
  a_toggle_max: assert property (spi_mode_oe_dev |-> tog_cnt <= STAGES)
    else $error("too many toggles");
  c_init: cover property ($rose(spi_mode_oe_dev));
  c_stages: cover property (gap == STAGE);
  c_irq: cover property ($rose(host_irq));
endmodule

//--- verification/tb_powerup_strap_config.sv
// Purpose: self-checking bench for both strap ends over apb
// Assumes: pclk 50 MHz, presetn async low, shortened counts
// Notes:   device outputs judged once init_done is high
module tb_powerup_strap_config;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  localparam int SETTLE = 4;
  localparam int STAGE  = 4;
  localparam int STAGES = 8;
  logic        pclk, presetn, psel, penable, pwrite, flash_ss_enable, fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, err, init_done, standby, spread_enable;
  logic        running_main, boot_wait, spi_is_host, i2c_is_host, spi_diag_ro, i2c_diag_ro;
  logic        use_checksum, diag_use_checksum, spi_cpol_ok0, spi_cpol_ok1;
  logic [5:0]  pats [4] = '{6'h00, 6'h3E, 6'h15, 6'h2A};
  int          fails, total_checks;
  strap_if bus();
  strap_dev #(.SETTLE(SETTLE), .STAGE(STAGE), .STAGES(STAGES)) strap_dev_inst (
    .pclk(pclk), .presetn(presetn), .pins(bus), .flash_ss_enable(flash_ss_enable),
    .fault(fault), .running_main(running_main), .boot_wait(boot_wait),
    .spi_is_host(spi_is_host), .i2c_is_host(i2c_is_host), .spi_diag_ro(spi_diag_ro),
    .i2c_diag_ro(i2c_diag_ro), .use_checksum(use_checksum),
    .diag_use_checksum(diag_use_checksum), .spi_cpol_ok0(spi_cpol_ok0),
    .spi_cpol_ok1(spi_cpol_ok1), .spread_enable(spread_enable), .init_done(init_done),
    .standby(standby));
  strap_host strap_host_inst (
    .pclk(pclk), .presetn(presetn), .pins(bus), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  strap_chk #(.STAGE(STAGE), .STAGES(STAGES)) strap_chk_inst (
    .pclk(pclk), .presetn(presetn), .power_on(bus.power_on), .spi_mode_pin(bus.spi_mode_pin),
    .spi_mode_o_dev(bus.spi_mode_o_dev), .spi_mode_oe_dev(bus.spi_mode_oe_dev),
    .host_irq(bus.host_irq));
  task results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task chkb(input string name, input logic exp, input logic got);
    chk(name, {31'h0, exp}, {31'h0, got});
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic rdy;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // response taken while it stands before the completing edge
    do
    begin
      @(negedge pclk);
      rdy = pready;
      rd  = prdata;
      err = pslverr;
      @(posedge pclk);
      n++;
    end
    while (rdy !== 1'b1 && n < 100);
    if (rdy !== 1'b1)
    begin
      fails++;
      results;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_init(input logic v);
    int n;
    n = 0;
    while (init_done !== v && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500)
    begin
      fails++;
      results;
    end
    @(posedge pclk);
  endtask
  task t_regs;
    apb(1'b0, CTRL_OFF, RESET_VAL);
    chk("ctrl_reset", RESET_VAL, rd);
    apb(1'b0, 12'h020, RESET_VAL);
    chkb("unmapped_err", 1'b1, err);
    chk("unmapped_data", 32'h0000_0000, rd);
    apb(1'b0, CFG_OFF, RESET_VAL);
    chk("cfg_settle", 32'(SETTLE_CYC), rd);
    $display("test regs done");
  endtask
  // s: 0 hold, 1 host sel, 2 integrity, 3 spi mode, 4 override, 5 flash setting
  task t_boot(input logic [5:0] s);
    logic [31:0] w;
    w = RESET_VAL;
    w[C_BOOT_HOLD] = s[0];
    w[C_HOST_SEL] = s[1];
    w[C_INTEG] = s[2];
    w[C_SPI_MODE] = s[3];
    w[C_SS_OVR] = s[4];
    flash_ss_enable <= s[5];
    apb(1'b1, CTRL_OFF, w);
    w[C_POWER_ON] = 1'b1;
    apb(1'b1, CTRL_OFF, w);
    wait_init(1'b1);
    apb(1'b0, STAT_OFF, RESET_VAL);
    chkb("pin_taken", 1'b1, rd[2]);
    chk("toggle_count", 32'(STAGES - 1), 32'(rd[10:3]));
    chkb("running_main", !s[0], running_main);
    chkb("boot_wait", s[0], boot_wait);
    chkb("spi_is_host", !s[1], spi_is_host);
    chkb("i2c_is_host", s[1], i2c_is_host);
    chkb("spi_diag_ro", s[1], spi_diag_ro);
    chkb("i2c_diag_ro", !s[1], i2c_diag_ro);
    chkb("use_checksum", s[2] == INTEG_SUM, use_checksum);
    if (!s[0])
      chkb("diag_use_checksum", s[2] == INTEG_SUM, diag_use_checksum);
    chkb("spi_cpol_ok0", s[3] == MODES_0_3, spi_cpol_ok0);
    chkb("spi_cpol_ok1", s[3] != MODES_0_3, spi_cpol_ok1);
    chkb("spread_enable", !s[0] & s[4] & s[5], spread_enable);
    apb(1'b1, CTRL_OFF, RESET_VAL);
    wait_init(1'b0);
    $display("test boot %h done", s);
  endtask
  task t_irq;
    logic [31:0] w;
    int          n;
    w = RESET_VAL;
    w[C_POWER_ON] = 1'b1;
    apb(1'b1, IRQ_MASK_OFF, RESET_VAL);
    apb(1'b1, CTRL_OFF, w);
    wait_init(1'b1);
    apb(1'b0, IRQ_STAT_OFF, RESET_VAL);
    fault <= 1'b1;
    n = 0;
    while (bus.host_irq !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    chkb("host_irq", 1'b1, bus.host_irq);
    chkb("standby", 1'b1, standby);
    chkb("irq_masked", 1'b0, irq);
    apb(1'b1, IRQ_MASK_OFF, 32'h0000_0001 << S_FAULT);
    apb(1'b0, IRQ_MASK_OFF, RESET_VAL);
    chk("irq_mask", 32'h0000_0001 << S_FAULT, rd);
    chkb("irq_unmasked", 1'b1, irq);
    apb(1'b0, IRQ_STAT_OFF, RESET_VAL);
    chkb("fault_sticky", 1'b1, rd[S_FAULT]);
    chkb("irq_cleared", 1'b0, irq);
    fault <= 1'b0;
    apb(1'b1, CTRL_OFF, RESET_VAL);
    wait_init(1'b0);
    chkb("host_irq_off", 1'b0, bus.host_irq);
    $display("test irq done");
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    flash_ss_enable = 1'b0;
    fault = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    for (int i = 0; i < 4; i++)
      t_boot(pats[i]);
    t_irq;
    results;
  end
endmodule
